// >>> common/trs_pkg.sv
// Constants for the three-rail reset supervisor core.
// Assumes a single 20 MHz clock; comparator results arrive asynchronously.
package trs_pkg;
  // ----------------------------------------
  // Clock and timing
  // ----------------------------------------
  localparam int CLOCK_HZ              = 20000000;
  localparam int HOLD_TIME_MS          = 200;      // Nominal hold, delay pin open
  localparam int REF_HOLD_TIME_MS      = 175;      // Scaling reference, delay pin open
  localparam int MANUAL_DEBOUNCE_NS    = 1000;     // Low time that counts as a request
  localparam int MANUAL_PULSE_MIN_NS   = 550;      // Shortest pulse the far side sends
  localparam int LATENCY_US            = 10;       // Typical trip to reset latency
  localparam int HOLD_CYCLES           = CLOCK_HZ / 1000 * HOLD_TIME_MS;
  localparam int REF_HOLD_CYCLES       = CLOCK_HZ / 1000 * REF_HOLD_TIME_MS;
  localparam int DEBOUNCE_CYCLES       = (MANUAL_DEBOUNCE_NS * (CLOCK_HZ / 1000000) + 999) / 1000;
  localparam int LATENCY_CYCLES        = LATENCY_US * (CLOCK_HZ / 1000000);
  localparam int HOLD_W                = 23;
  localparam int SCALE_W               = 4;
  localparam int DEB_W                 = 6;
  localparam logic [SCALE_W-1:0] SCALE_ONE = 4'h1;
  localparam logic [DEB_W-1:0]   DEB_LAST  = DEB_W'(DEBOUNCE_CYCLES - 1);
  // ----------------------------------------
  // Supervisor states
  // ----------------------------------------
  typedef enum logic [0:0] {
    ST_HOLD    = 1'b0,
    ST_RELEASE = 1'b1
  } trs_state_t;
endpackage

// >>> hdl/trs_supervisor.sv
// Digital core of a three-rail reset supervisor with manual reset.
// Assumes comparator outputs and the manual reset pin are asynchronous to clock,
// and that the analog power-on circuit drives srst while the main supply is low.
//
// Overview of operation
// [R1] Reset while any undervoltage rail is low
// [R2] Overvoltage variant: third rail high trips reset
// [R3] Release only after continuous compliance for hold
// [R4] Hold nominally 200 ms, capacitor lengthens period
// [R5] Active-low output low from power-up
// [R6] Both outputs change in the same cycle
// [R7] Manual request counts after 1 us low
// [R8] Requester holds manual reset low 1 us
// [R9] Full hold time again after manual release
// [R10] Outputs are complements of one condition
// [R11] Open pin reference hold 175 ms, scaled; core scales the 200 ms HOLD_CYCLES instead
// [R12] Reset asserts within typical 10 us
// [R13] Manual pulse at least 550 ns wide
// [R14] Hold counter clears on any fault
// [R15] Async inputs synchronised before use
`timescale 1ns/1ps
module trs_supervisor #(
  parameter int  HOLD_CYCLES = trs_pkg::HOLD_CYCLES,  // Hold count at scale one
  parameter bit  OVER_VARIANT = 1'b0                  // 1: third rail watched for overvoltage
) (
  input  wire logic                         clock,          // 20 MHz clock
  input  wire logic                         srst,           // Synchronous reset, high
  input  wire logic                         mainSupplyOk,   // Main supply above its trip
  input  wire logic                         secondRailOk,   // Second rail above its trip
  input  wire logic                         thirdRailAbove, // Third rail above its trip
  input  wire logic                         manual_reset_n, // Manual request, low
  input  wire logic [trs_pkg::SCALE_W-1:0]  holdScale,      // Delay capacitor multiplier, static
  output logic                              resetHigh,      // Active-high reset
  output logic                              reset_n         // Active-low reset
);

  // ----------------------------------------
  // Input synchronisers
  // ----------------------------------------
  logic [3:0] syncA_reg;
  logic [3:0] syncB_reg;
  logic [3:0] syncC_reg;
  logic [3:0] stable_reg;
  logic [3:0] rawIn;

  assign rawIn = {manual_reset_n, thirdRailAbove, secondRailOk, mainSupplyOk};

  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      syncA_reg <= 4'h0;
      syncB_reg <= 4'h0;
      syncC_reg <= 4'h0;
    end
    else
    begin
      syncA_reg <= rawIn;      // R15
      syncB_reg <= syncA_reg;  // R15
      syncC_reg <= syncB_reg;
    end
  end

  // A change counts once the second and third stages agree
  always_ff @(posedge clock)
  begin
    if (srst)
      stable_reg <= 4'h0;
    else
      for (int i = 0; i < 4; i++)
        if (syncB_reg[i] == syncC_reg[i])
          stable_reg[i] <= syncC_reg[i];  // R15
  end

  // ----------------------------------------
  // Manual reset debounce
  // ----------------------------------------
  logic [trs_pkg::DEB_W-1:0] debCount_reg;
  logic                      manualReq_reg;

  // Short glitches from a bouncing button are absorbed here
  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      debCount_reg  <= '0;
      manualReq_reg <= 1'b0;
    end
    else if (stable_reg[3])
    begin
      debCount_reg  <= '0;
      manualReq_reg <= 1'b0;
    end
    else if (debCount_reg == trs_pkg::DEB_LAST)
      manualReq_reg <= 1'b1;  // R7
    else
      debCount_reg <= debCount_reg + 1'b1;  // R7
  end

  // ----------------------------------------
  // Fault combination
  // ----------------------------------------
  logic thirdFault;
  logic fault;

  assign thirdFault = OVER_VARIANT ? stable_reg[2] : ~stable_reg[2];  // R1 R2
  assign fault      = ~stable_reg[0] | ~stable_reg[1] | thirdFault | manualReq_reg;  // R1 R9

  // ----------------------------------------
  // Hold counter with scaled prescale
  // ----------------------------------------
  logic [trs_pkg::HOLD_W-1:0]  holdCount_reg;
  logic [trs_pkg::SCALE_W-1:0] preCount_reg;
  logic [trs_pkg::SCALE_W-1:0] scaleEff;
  logic                        holdDone;
  trs_pkg::trs_state_t         state_reg;

  // Zero scale would run the prescale to sixteen, so treat it as one
  assign scaleEff = (holdScale == '0) ? trs_pkg::SCALE_ONE : holdScale;  // R4 R11
  assign holdDone = (holdCount_reg == trs_pkg::HOLD_W'(HOLD_CYCLES - 1)) && (preCount_reg == scaleEff - 1'b1);

  always_ff @(posedge clock)
  begin
    if (srst || fault)
    begin
      holdCount_reg <= '0;  // R14 R3
      preCount_reg  <= '0;
    end
    else if (state_reg == trs_pkg::ST_HOLD)
    begin
      if (preCount_reg == scaleEff - 1'b1)
      begin
        preCount_reg  <= '0;
        holdCount_reg <= holdCount_reg + 1'b1;  // R4
      end
      else
        preCount_reg <= preCount_reg + 1'b1;  // R11
    end
  end

  // ----------------------------------------
  // Reset state and outputs
  // ----------------------------------------
  always_ff @(posedge clock)
  begin
    if (srst || fault)
      state_reg <= trs_pkg::ST_HOLD;  // R1 R12
    else
    begin
      unique case (state_reg)
        trs_pkg::ST_HOLD:
          if (holdDone)
            state_reg <= trs_pkg::ST_RELEASE;  // R3
        trs_pkg::ST_RELEASE:
          state_reg <= trs_pkg::ST_RELEASE;
      endcase
    end
  end

  // Both outputs come from one register image so they never disagree
  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      resetHigh <= 1'b1;  // R5
      reset_n   <= 1'b0;  // R5
    end
    else
    begin
      resetHigh <= (state_reg == trs_pkg::ST_HOLD);   // R6 R10
      reset_n   <= (state_reg != trs_pkg::ST_HOLD);   // R6 R10
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  a_outputs_complement: assert property (@(posedge clock) disable iff (srst)  // R10
    resetHigh != reset_n)
    else $error("reset outputs not complementary");

  a_fault_asserts_reset: assert property (@(posedge clock) disable iff (srst)  // R1
    (~stable_reg[0] | ~stable_reg[1]) |-> ##2 resetHigh)
    else $error("rail fault did not assert reset");

  a_third_rail_fault: assert property (@(posedge clock) disable iff (srst)  // R2
    thirdFault |-> ##2 !reset_n)
    else $error("third rail fault did not assert reset");

  a_fault_clears_count: assert property (@(posedge clock) disable iff (srst)  // R14
    fault |=> (holdCount_reg == '0) && (preCount_reg == '0))
    else $error("hold counter not cleared by fault");

  a_release_needs_hold: assert property (@(posedge clock) disable iff (srst)  // R3
    $rose(reset_n) |-> $past(holdDone, 2))
    else $error("reset released before hold expired");

  a_done_releases: assert property (@(posedge clock) disable iff (srst)  // R6
    (holdDone && !fault) |-> ##2 (reset_n && !resetHigh))
    else $error("hold expiry did not release both outputs");

  a_manual_debounce: assert property (@(posedge clock) disable iff (srst)  // R7
    $rose(manualReq_reg) |-> !$past(stable_reg[3], trs_pkg::DEBOUNCE_CYCLES))
    else $error("manual request taken before debounce time");

  a_manual_holds_reset: assert property (@(posedge clock) disable iff (srst)  // R9
    manualReq_reg |-> ##2 resetHigh)
    else $error("manual request did not hold reset");

  a_latency_bound: assert property (@(posedge clock) disable iff (srst)  // R12
    $fell(mainSupplyOk) |-> ##[1:6] resetHigh)
    else $error("reset latency too long");

  a_power_up_low: assert property (@(posedge clock)  // R5
    srst |=> !reset_n)
    else $error("active-low reset not low after power-up");

  a_power_up_high: assert property (@(posedge clock)  // R5
    srst |=> resetHigh)
    else $error("active-high reset not high after power-up");

  a_srst_clears_req: assert property (@(posedge clock)  // R7
    srst |=> !manualReq_reg)
    else $error("manual request survived reset");

  a_outputs_together: assert property (@(posedge clock) disable iff (srst)  // R6
    $changed(resetHigh) |-> $changed(reset_n))
    else $error("reset outputs changed in different cycles");

  a_third_polarity: assert property (@(posedge clock) disable iff (srst)  // R2
    (stable_reg[2] == OVER_VARIANT) |-> ##2 resetHigh)
    else $error("third rail level of the watched side did not reset");

  a_fault_to_hold: assert property (@(posedge clock) disable iff (srst)  // R1
    fault |=> (state_reg == trs_pkg::ST_HOLD))
    else $error("fault did not return state to hold");

  // ----------------------------------------
  // Checks on input conditioning
  // ----------------------------------------
  a_sync_second_stage: assert property (@(posedge clock) disable iff (srst)  // R15
    !$past(srst) |-> (syncB_reg == $past(syncA_reg)))
    else $error("synchroniser second stage skipped a value");

  a_glitch_ignored: assert property (@(posedge clock) disable iff (srst)  // R15
    (syncB_reg[3] != syncC_reg[3]) |=> $stable(stable_reg[3]))
    else $error("manual input changed while stages disagreed");

  a_debounce_clear: assert property (@(posedge clock) disable iff (srst)  // R7
    stable_reg[3] |=> (!manualReq_reg && (debCount_reg == '0)))
    else $error("debounce not cleared by released manual input");

  a_manual_release_hold: assert property (@(posedge clock) disable iff (srst)  // R9
    $fell(manualReq_reg) |-> ##1 resetHigh)
    else $error("reset not held after manual release");

  // ----------------------------------------
  // Checks on the hold counter
  // ----------------------------------------
  a_prescale_bounded: assert property (@(posedge clock) disable iff (srst)  // R11
    preCount_reg < scaleEff)
    else $error("prescale count beyond scale");

  a_prescale_wrap: assert property (@(posedge clock) disable iff (srst)  // R11
    ((state_reg == trs_pkg::ST_HOLD) && !fault && (preCount_reg == scaleEff - 1'b1)) |=> (preCount_reg == '0))
    else $error("prescale did not wrap at scale");

  a_release_stays: assert property (@(posedge clock) disable iff (srst)  // R3
    ((state_reg == trs_pkg::ST_RELEASE) && !fault) |=> (state_reg == trs_pkg::ST_RELEASE))
    else $error("release dropped without a fault");

  a_count_frozen: assert property (@(posedge clock) disable iff (srst)  // R14
    ((state_reg == trs_pkg::ST_RELEASE) && !fault) |=> $stable(holdCount_reg))
    else $error("hold counter moved after release");

  a_hold_drives_high: assert property (@(posedge clock) disable iff (srst)  // R10
    (state_reg == trs_pkg::ST_HOLD) |=> resetHigh)
    else $error("hold state did not drive reset");

  // ----------------------------------------
  // Compliance run length check
  // ----------------------------------------
  // Counted apart from the hold counter so a broken prescale cannot hide
  // Saturates instead of wrapping during very long runs
  logic [31:0] okRun_reg;

  always_ff @(posedge clock)
  begin
    if (srst || fault)
      okRun_reg <= 32'h0;
    else if (okRun_reg != 32'hFFFFFFFF)
      okRun_reg <= okRun_reg + 32'h1;
  end

  a_release_after_run: assert property (@(posedge clock) disable iff (srst)  // R3
    $rose(reset_n) |-> (okRun_reg >= HOLD_CYCLES * scaleEff))
    else $error("release before a full compliant run");

endmodule

// >>> verif/trs_host_model.sv
// Model of the processor side that asks the supervisor for a manual reset.
// Assumes the bench calls pulse() from one process at a time.
`timescale 1ns/1ps
module trs_host_model (
  input  wire logic clock,          // Supervisor clock
  output logic      manual_reset_n  // Manual request, low
);
  // ----------------------------------------
  // Request line
  // ----------------------------------------
  // Idle level is the pin's pull-up, so the line is never left floating
  initial manual_reset_n = 1'b1;

  // A request is one unbroken low level; the caller picks its length
  task automatic pulse(input int lowCycles);
    @(negedge clock);
    manual_reset_n = 1'b0;
    repeat (lowCycles) @(negedge clock);
    manual_reset_n = 1'b1;
  endtask
endmodule

// >>> verif/trs_supervisor_tb.sv
// Self-checking bench for the three-rail reset supervisor core.
// Assumes HOLD_CYCLES is shortened to 50; one undervoltage and one overvoltage unit share inputs.
`timescale 1ns/1ps
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin err_count++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, (a), (b)); end end
module trs_supervisor_tb;
  localparam int HOLD = 50;
  typedef struct packed {logic m; logic s; logic t; logic expUv; logic expOv;} trs_row_t;
  logic                        clock = 1'b0;
  logic                        srst = 1'b1;
  logic                        mainSupplyOk = 1'b1;
  logic                        secondRailOk = 1'b1;
  logic                        thirdRailAbove = 1'b1;
  logic [trs_pkg::SCALE_W-1:0] holdScale = 4'h1;
  logic                        manual_reset_n;
  logic                        resetHigh, reset_n, ovHigh, ovN;
  int                          err_count = 0;
  int                          tests_run = 0;
  int                          n;
  // Rows: rails (main, second, third) and the expected reset of each variant
  trs_row_t rows [6] = '{5'b111_01, 5'b110_10, 5'b011_11, 5'b100_11, 5'b000_11, 5'b111_01};

  initial forever #25 clock = ~clock;

  trs_host_model host (.clock(clock), .manual_reset_n(manual_reset_n));
  trs_supervisor #(.HOLD_CYCLES(HOLD), .OVER_VARIANT(1'b0)) uut (.clock(clock), .srst(srst),
    .mainSupplyOk(mainSupplyOk), .secondRailOk(secondRailOk), .thirdRailAbove(thirdRailAbove),
    .manual_reset_n(manual_reset_n), .holdScale(holdScale), .resetHigh(resetHigh), .reset_n(reset_n));
  trs_supervisor #(.HOLD_CYCLES(HOLD), .OVER_VARIANT(1'b1)) uutOv (.clock(clock), .srst(srst),
    .mainSupplyOk(mainSupplyOk), .secondRailOk(secondRailOk), .thirdRailAbove(thirdRailAbove),
    .manual_reset_n(manual_reset_n), .holdScale(holdScale), .resetHigh(ovHigh), .reset_n(ovN));

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  task automatic complete_run;
    $display("Comparisons %0d, mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  task automatic cycles(input int k);
    repeat (k) @(negedge clock);
  endtask

  // Counts edges until the undervoltage unit releases; a hang ends the run
  task automatic wait_release(input int hi, output int cnt);
    cnt = 0;
    while (resetHigh === 1'b1 && cnt < hi + 20)
    begin
      @(negedge clock);
      cnt++;
    end
    if (cnt >= hi + 20)
    begin
      err_count++;
      complete_run();
    end
  endtask

  // ----------------------------------------
  // Sequence
  // ----------------------------------------
  initial
  begin
    repeat (8) @(negedge clock);
    `CHK(reset_n, 1'b0)
    `CHK(resetHigh, 1'b1)
    srst = 1'b0;
    wait_release(HOLD + 10, n);
    `CHK(n >= HOLD && n <= HOLD + 10, 1'b1)
    foreach (rows[i])
    begin
      {mainSupplyOk, secondRailOk, thirdRailAbove} = {rows[i].m, rows[i].s, rows[i].t};
      cycles(80);
      `CHK(resetHigh, rows[i].expUv)
      `CHK(ovHigh, rows[i].expOv)
      `CHK(reset_n, ~rows[i].expUv)
      `CHK(ovN, ~rows[i].expOv)
    end
    // Fault latency, then a short dropout in mid-hold must restart the count
    secondRailOk = 1'b0;
    cycles(8);
    `CHK(resetHigh, 1'b1)
    secondRailOk = 1'b1;
    cycles(30);
    secondRailOk = 1'b0;
    cycles(5);
    secondRailOk = 1'b1;
    wait_release(HOLD + 10, n);
    `CHK(n >= HOLD, 1'b1)
    // Request longer than the minimum pulse but under the debounce time, then one over it that must restart a full hold
    host.pulse(12);
    cycles(20);
    `CHK(resetHigh, 1'b0)
    host.pulse(30);
    `CHK(resetHigh, 1'b1)
    wait_release(HOLD + 12, n);
    `CHK(n >= HOLD && n <= HOLD + 12, 1'b1)
    // Capacitor multiplier applied across a reset, since it is static
    srst = 1'b1;
    holdScale = 4'h3;
    cycles(2);
    srst = 1'b0;
    wait_release(3 * HOLD + 10, n);
    `CHK(n >= 3 * HOLD && n <= 3 * HOLD + 10, 1'b1)
    // A zero multiplier must behave as one
    srst = 1'b1;
    holdScale = 4'h0;
    cycles(2);
    srst = 1'b0;
    wait_release(HOLD + 10, n);
    `CHK(n >= HOLD && n <= HOLD + 10, 1'b1)
    complete_run();
  end
endmodule
